// ==== common/cfg_pin_pkg.sv ====
// Constants and types shared by the configuration clock and data pin controller
`default_nettype none
package cfg_pin_pkg;

   // System clock period and generated configuration clock half period
   localparam int SYS_CLK_NS   = 50;
   localparam int CLK_HALF_NS  = 400;
   // Least time, so round up to whole system cycles
   localparam int CLK_HALF_CYC = (CLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam logic [3:0] HALF_LAST = 4'(CLK_HALF_CYC - 1);

   // Data path sizes
   localparam int WORD_W     = 16;
   localparam int FIFO_DEPTH = 32;

   // Serial flash read command, shifted out first
   localparam logic [7:0] FLASH_READ_CMD = 8'h03;
   localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;
   localparam logic [2:0] STRAP_WAIT     = 3'h4;  // Strap sync settles on the fourth edge

   // Reset values
   localparam logic [3:0] DIV_RESET   = 4'h0;
   localparam logic [2:0] BIT_RESET   = 3'h0;
   localparam logic [7:0] BYTE_RESET  = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // Configuration schemes, taken from the strap pins
   typedef enum logic [1:0] {
      passive_serial_scheme        = 2'h0,
      fast_passive_parallel_scheme = 2'h1,
      active_serial_scheme         = 2'h2,
      active_parallel_scheme       = 2'h3
   } scheme_type;

   // Loader states
   typedef enum logic [4:0] {
      st_wait    = 5'h01,
      st_passive = 5'h02,
      st_cmd     = 5'h04,
      st_read    = 5'h08,
      st_done    = 5'h10
   } state_type;

endpackage : cfg_pin_pkg

`default_nettype wire

// ==== hw/config_clock_data_pin_control.sv ====
// Configuration clock and low data pin controller with its crossing and word FIFO
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a bit changes once stages two and three agree
module sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk,    // Destination clock
   input  wire logic         rst_n,  // Destination reset, synchronous, active low
   input  wire logic [W-1:0] d,      // Asynchronous level
   output logic      [W-1:0] q       // Filtered level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // Shift chain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Agreement filter per bit
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            q[i] <= 1'b0;
         end else if (s2_q[i] == s3_q[i]) begin
            q[i] <= s3_q[i];
         end
      end
   end
endmodule : sync3

// Synchronous FIFO; depth must be a power of two
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,        // System clock
   input  wire logic             rst_n,      // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] in_data,    // Word to store
   input  wire logic             in_valid,   // Word offered
   output logic                  in_ready,   // Room for a word
   output logic      [WIDTH-1:0] out_data,   // Oldest word
   output logic                  out_valid,  // A word is held
   input  wire logic             out_ready   // Drain takes the word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             full;
   logic             push;
   logic             pop;

   // Status from pointers with a wrap bit
   assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem[rd_q[AW-1:0]];
   assign push      = in_valid && !full;
   assign pop       = out_valid && out_ready;

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end
endmodule : word_fifo

// Behaviour
// - Passive schemes capture data on rising edges of the external clock; a word done before the last is acked is dropped.
// - Active schemes generate the configuration clock and drive it outward.
// - Active schemes park the clock pin low once configuration completes.
// - Active schemes may hand the clock pin to user logic in user mode.
// - Passive schemes never offer the clock pin to user logic.
// - Clock transitions after configuration leave the configured state untouched.
// - Serial schemes move one bit per clock on data bit zero.
// - After active serial, data bit zero stays a dedicated input.
// - After passive schemes, data bit zero follows the dual-purpose setting.
// - After active parallel, data bit zero is a user-controlled bidirectional pin.
// - Active serial drives the flash command stream on data bit one.
// - Outside active serial, data bit one is a data input until configuration completes.
// - After active serial, data bit one stays a dedicated output.
// - Passive serial leaves data bit one tri-stated during configuration.
// - After fast passive parallel, data bit one follows the dual-purpose setting.
// - Active parallel moves eight or sixteen bits per clock.
// - After active parallel, data bit one is a user-controlled bidirectional pin.
module config_clock_data_pin_control (
   input  wire logic        clk_sys,              // Core clock, 20 MHz
   input  wire logic        rst_n,                // Synchronous reset, active low
   input  wire logic        config_clock,         // Clock pin as input, link domain
   input  wire logic [1:0]  scheme_strap,         // Scheme select pins
   input  wire logic        ap_word_wide,         // Parallel flash is 16 bits wide
   input  wire logic        dual_purpose_user_io, // Dual-purpose pins become user pins
   input  wire logic        release_clock_pin,    // Hand clock pin to user logic
   input  wire logic        config_complete,      // Core reports image loaded
   input  wire logic        user_clk_o,           // User drive for clock pin
   input  wire logic        user_clk_oe,          // User enable for clock pin
   input  wire logic        user_d0_o,            // User drive for data bit zero
   input  wire logic        user_d0_oe,           // User enable for data bit zero
   input  wire logic        user_d1_o,            // User drive for data bit one
   input  wire logic        user_d1_oe,           // User enable for data bit one
   input  wire logic [15:0] data_pins,            // Data pin levels
   output logic             clk_pin_o,            // Clock pin drive
   output logic             clk_pin_oe,           // Clock pin enable
   output logic             d0_pin_o,             // Data bit zero drive
   output logic             d0_pin_oe,            // Data bit zero enable
   output logic             d1_pin_o,             // Data bit one drive
   output logic             d1_pin_oe,            // Data bit one enable
   output logic [15:0]      word_data,            // Configuration word
   output logic             word_valid,           // Word held
   input  wire logic        word_ready,           // Core takes the word
   output logic             user_mode,            // Configuration over
   output logic             overrun               // Passive word lost, sticky
);
   cfg_pin_pkg::scheme_type scheme_q;
   cfg_pin_pkg::state_type  state_q;
   cfg_pin_pkg::state_type  state_d;
   logic [1:0]  strap_s;
   logic [2:0]  strap_cnt_q;
   logic        strap_taken_q;
   logic        is_passive;
   logic        is_as;
   logic        is_ap;
   logic        done;
   logic [15:0] pin_q;
   logic [3:0]  div_q;
   logic        clk_q;
   logic        run;
   logic        rise_tick;
   logic [7:0]  cmd_q;
   logic [2:0]  bit_q;
   logic [7:0]  sh_q;
   logic        push;
   logic [15:0] push_data;
   logic        fifo_in_ready;
   logic [15:0] fifo_out_data;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic        link_en_q;
   logic        req_s;
   logic        ack_s_q;
   logic        take;
   logic        clk_d;
   logic        clk_oe_d;
   logic        d0_d;
   logic        d0_oe_d;
   logic        d1_d;
   logic        d1_oe_d;
   // Link domain
   logic [1:0]  lrst_q;
   logic        link_rst_n;
   logic [1:0]  link_cfg;
   logic        ack_l;
   logic [2:0]  bit_l_q;
   logic [7:0]  sh_l_q;
   logic [15:0] word_l_q;
   logic        req_l_q;
   logic        ovr_l_q;
   logic        busy_l;

   assign is_passive = (scheme_q == cfg_pin_pkg::passive_serial_scheme)
                    || (scheme_q == cfg_pin_pkg::fast_passive_parallel_scheme);
   assign is_as      = (scheme_q == cfg_pin_pkg::active_serial_scheme);
   assign is_ap      = (scheme_q == cfg_pin_pkg::active_parallel_scheme);
   assign done       = (state_q == cfg_pin_pkg::st_done);

   // Strap pins are taken one edge after their synchroniser has settled, not before
   sync3 #(.W(2)) u_strap_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (scheme_strap),
      .q     (strap_s)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         strap_cnt_q   <= 3'h0;
         strap_taken_q <= 1'b0;
         scheme_q      <= cfg_pin_pkg::passive_serial_scheme;
      end else if (!strap_taken_q) begin
         strap_cnt_q <= strap_cnt_q + 3'h1;
         if (strap_cnt_q == cfg_pin_pkg::STRAP_WAIT) begin
            strap_taken_q <= 1'b1;
            scheme_q      <= cfg_pin_pkg::scheme_type'(strap_s);
         end
      end
   end

   // Data pins into the core domain for the active schemes
   sync3 #(.W(16)) u_pin_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (data_pins),
      .q     (pin_q)
   );

   // Loader sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         cfg_pin_pkg::st_wait: begin
            if (strap_taken_q) begin
               if (is_passive) state_d = cfg_pin_pkg::st_passive;
               else if (is_as) state_d = cfg_pin_pkg::st_cmd;
               else state_d = cfg_pin_pkg::st_read;
            end
         end
         cfg_pin_pkg::st_cmd: begin
            if (rise_tick && bit_q == cfg_pin_pkg::BYTE_LAST_BIT) state_d = cfg_pin_pkg::st_read;
         end
         default: ;
      endcase
      if (state_q != cfg_pin_pkg::st_wait && config_complete) state_d = cfg_pin_pkg::st_done;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) state_q <= cfg_pin_pkg::st_wait;
      else state_q <= state_d;
   end

   // Clock divider; stalls while the FIFO is full so the flash waits
   assign run       = (state_q == cfg_pin_pkg::st_cmd || state_q == cfg_pin_pkg::st_read)
                   && fifo_in_ready;
   assign rise_tick = run && (div_q == cfg_pin_pkg::HALF_LAST) && !clk_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n || done) begin
         div_q <= cfg_pin_pkg::DIV_RESET;
         clk_q <= 1'b0;
      end else if (run) begin
         if (div_q == cfg_pin_pkg::HALF_LAST) begin
            div_q <= cfg_pin_pkg::DIV_RESET;
            clk_q <= ~clk_q;
         end else begin
            div_q <= div_q + 4'h1;
         end
      end
   end

   // Command shifter changes on the falling edge, bit counter on the rising edge
   always_ff @(posedge clk_sys) begin
      if (!rst_n || state_q == cfg_pin_pkg::st_wait) begin
         cmd_q <= cfg_pin_pkg::FLASH_READ_CMD;
         bit_q <= cfg_pin_pkg::BIT_RESET;
      end else if (run && div_q == cfg_pin_pkg::HALF_LAST && clk_q
                   && state_q == cfg_pin_pkg::st_cmd) begin
         cmd_q <= {cmd_q[6:0], 1'b0};
      end else if (rise_tick) begin
         bit_q <= bit_q + 3'h1;
      end
   end

   // Active read: serial bytes LSB first, parallel words per clock
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sh_q <= cfg_pin_pkg::BYTE_RESET;
      end else if (rise_tick && state_q == cfg_pin_pkg::st_read && is_as) begin
         sh_q <= {pin_q[0], sh_q[7:1]};
      end
   end

   // Passive words cross by toggle handshake
   always_ff @(posedge clk_sys) begin
      if (!rst_n) link_en_q <= 1'b0;
      else link_en_q <= (state_q == cfg_pin_pkg::st_passive);
   end

   sync3 #(.W(1)) u_req_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (req_l_q),
      .q     (req_s)
   );

   assign take = (req_s != ack_s_q) && fifo_in_ready && (state_q == cfg_pin_pkg::st_passive);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) ack_s_q <= 1'b0;
      else if (take) ack_s_q <= ~ack_s_q;
   end

   // FIFO feed from the active reader or the passive crossing
   always_comb begin
      push      = 1'b0;
      push_data = cfg_pin_pkg::WORD_RESET;
      if (take) begin
         push      = 1'b1;
         push_data = word_l_q;
      end else if (rise_tick && state_q == cfg_pin_pkg::st_read) begin
         if (is_ap) begin
            push      = 1'b1;
            push_data = ap_word_wide ? pin_q : {8'h00, pin_q[7:0]};
         end else if (bit_q == cfg_pin_pkg::BYTE_LAST_BIT) begin
            push      = 1'b1;
            push_data = {8'h00, pin_q[0], sh_q[7:1]};
         end
      end
   end

   word_fifo #(.WIDTH(cfg_pin_pkg::WORD_W), .DEPTH(cfg_pin_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk_sys),
      .rst_n     (rst_n),
      .in_data   (push_data),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready)
   );

   // Output stage so the word port comes from flops
   assign fifo_out_ready = !word_valid || word_ready;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         word_valid <= 1'b0;
         word_data  <= cfg_pin_pkg::WORD_RESET;
      end else if (fifo_out_ready) begin
         word_valid <= fifo_out_valid;
         if (fifo_out_valid) word_data <= fifo_out_data;
      end
   end

   // Pin steering during and after configuration
   always_comb begin
      clk_d    = 1'b0;
      clk_oe_d = 1'b0;
      d0_d     = 1'b0;
      d0_oe_d  = 1'b0;
      d1_d     = 1'b0;
      d1_oe_d  = 1'b0;
      if (!done) begin
         if (!is_passive && state_q != cfg_pin_pkg::st_wait) begin
            clk_d    = clk_q;
            clk_oe_d = 1'b1;
         end
         if (is_as && state_q != cfg_pin_pkg::st_wait) begin
            d1_d    = cmd_q[7];
            d1_oe_d = 1'b1;
         end
      end else begin
         if (!is_passive) begin
            clk_d    = release_clock_pin ? user_clk_o : 1'b0;
            clk_oe_d = release_clock_pin ? user_clk_oe : 1'b1;
         end
         if (is_as) begin
            d1_d    = user_d1_o;
            d1_oe_d = 1'b1;
         end else if (is_ap || dual_purpose_user_io) begin
            d0_d    = user_d0_o;
            d0_oe_d = user_d0_oe;
            d1_d    = user_d1_o;
            d1_oe_d = user_d1_oe;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clk_pin_o  <= 1'b0;
         clk_pin_oe <= 1'b0;
         d0_pin_o   <= 1'b0;
         d0_pin_oe  <= 1'b0;
         d1_pin_o   <= 1'b0;
         d1_pin_oe  <= 1'b0;
         user_mode  <= 1'b0;
      end else begin
         clk_pin_o  <= clk_d;
         clk_pin_oe <= clk_oe_d;
         d0_pin_o   <= d0_d;
         d0_pin_oe  <= d0_oe_d;
         d1_pin_o   <= d1_d;
         d1_pin_oe  <= d1_oe_d;
         user_mode  <= done;
      end
   end

   // Link domain reset and control crossing
   always_ff @(posedge config_clock) begin
      lrst_q <= {lrst_q[0], rst_n};
   end
   assign link_rst_n = lrst_q[1];

   sync3 #(.W(2)) u_cfg_sync (
      .clk   (config_clock),
      .rst_n (link_rst_n),
      .d     ({scheme_q == cfg_pin_pkg::fast_passive_parallel_scheme, link_en_q}),
      .q     (link_cfg)
   );

   sync3 #(.W(1)) u_ack_sync (
      .clk   (config_clock),
      .rst_n (link_rst_n),
      .d     (ack_s_q),
      .q     (ack_l)
   );

   assign busy_l = (req_l_q != ack_l);

   // Capture on the host's clock; edges outside the passive phase are ignored
   always_ff @(posedge config_clock) begin
      if (!link_rst_n) begin
         bit_l_q  <= cfg_pin_pkg::BIT_RESET;
         sh_l_q   <= cfg_pin_pkg::BYTE_RESET;
         word_l_q <= cfg_pin_pkg::WORD_RESET;
         req_l_q  <= 1'b0;
         ovr_l_q  <= 1'b0;
      end else if (link_cfg[0]) begin
         if (!link_cfg[1]) begin
            sh_l_q  <= {data_pins[0], sh_l_q[7:1]};
            bit_l_q <= bit_l_q + 3'h1;
         end
         if (link_cfg[1] || bit_l_q == cfg_pin_pkg::BYTE_LAST_BIT) begin
            if (busy_l) begin
               ovr_l_q <= 1'b1;
            end else begin
               word_l_q <= link_cfg[1] ? {8'h00, data_pins[7:0]}
                                       : {8'h00, data_pins[0], sh_l_q[7:1]};
               req_l_q  <= ~req_l_q;
            end
         end
      end
   end

   sync3 #(.W(1)) u_ovr_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (ovr_l_q),
      .q     (overrun)
   );

   // Checks
   sequence s_active_done;
      done && !is_passive;
   endsequence

   sequence s_clk_tick;
      run && div_q == cfg_pin_pkg::HALF_LAST && !config_complete;
   endsequence

   chk_clk_generated: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_clk_tick |=> ##1 (clk_pin_o != $past(clk_pin_o) && clk_pin_oe))
      else $error("generated clock did not toggle");
   chk_clk_parked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_active_done ##0 !release_clock_pin |=> (!clk_pin_o && clk_pin_oe))
      else $error("clock pin not parked low");
   chk_clk_released: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_active_done ##0 release_clock_pin |=> clk_pin_oe == $past(user_clk_oe))
      else $error("clock pin not released");
   chk_clk_passive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      strap_taken_q && is_passive |=> !clk_pin_oe)
      else $error("clock pin driven in passive scheme");
   chk_ignore_late: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done |-> !push)
      else $error("word taken after configuration");
   chk_d0_dedicated: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done && is_as |=> !d0_pin_oe)
      else $error("data bit zero driven after serial load");
   chk_d0_dual: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done && is_passive |=> d0_pin_oe == ($past(dual_purpose_user_io) && $past(user_d0_oe)))
      else $error("data bit zero ignores dual-purpose setting");
   chk_ap_bidir: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done && is_ap |=> d0_pin_oe == $past(user_d0_oe) && d1_pin_oe == $past(user_d1_oe))
      else $error("parallel pins not under user control");
   chk_d1_command: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_q == cfg_pin_pkg::st_cmd && !config_complete |=> d1_pin_oe && d1_pin_o == $past(cmd_q[7]))
      else $error("command bit not driven");
   chk_d1_input: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !is_as && !done |=> !d1_pin_oe)
      else $error("data bit one driven as input");
   chk_d1_dedicated: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done && is_as |=> d1_pin_oe)
      else $error("data bit one not kept as output");
   chk_d1_dual: assert property (@(posedge clk_sys) disable iff (!rst_n)
      done && is_passive |=> d1_pin_oe == ($past(dual_purpose_user_io) && $past(user_d1_oe)))
      else $error("data bit one ignores dual-purpose setting");
   chk_ap_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
      push && is_ap && !ap_word_wide |-> push_data[15:8] == 8'h00)
      else $error("byte-wide word carries upper bits");
   chk_link_capture: assert property (@(posedge config_clock) disable iff (!link_rst_n)
      link_cfg[0] && !link_cfg[1] |=> sh_l_q[7] == $past(data_pins[0]))
      else $error("serial bit not captured on clock rise");

endmodule : config_clock_data_pin_control

`default_nettype wire

// ==== verif/cfg_host_model.sv ====
// Host and flash model driving the configuration clock and data pins
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input  wire logic  active,   // Flash drives its word
   output logic       host_clk, // Host clock drive
   output logic [15:0] pins     // Host or flash data drive
);
   logic drive = 1'b0;
   initial host_clk = 1'b0;
   initial pins = 16'h0000;
   // Released lines change every 25 ns so no stale level reads as data
   always #25 pins = active ? 16'hc3a5 : (drive ? pins : ~pins);
   // Frame of n clock edges at 32 ns, data held across each edge, clock parked low
   task automatic frame(input int n, input logic [15:0] d);
      drive = 1'b1;
      pins = d;
      repeat (n) begin
         #16 host_clk = 1'b1;
         #16 host_clk = 1'b0;
      end
      drive = 1'b0;
   endtask : frame
endmodule : cfg_host_model
`default_nettype wire

// ==== verif/config_clock_data_pin_control_tb.sv ====
// Self-checking bench for the configuration pin controller
`timescale 1ns/1ps
`default_nettype none
module config_clock_data_pin_control_tb;
   logic clk_sys = 1'b0, rst_n = 1'b0, word_ready = 1'b1, dual = 1'b0, rel = 1'b0, done = 1'b0;
   logic [1:0] strap = 2'h0;
   logic wide = 1'b0;
   logic [5:0] usr = 6'h00;
   logic clk_pin_o, clk_pin_oe, d0_pin_o, d0_pin_oe, d1_pin_o, d1_pin_oe, user_mode, overrun;
   logic [15:0] word_data, pins;
   logic word_valid, host_clk;
   wire logic config_clock;
   wire logic [15:0] data_pins;
   logic [15:0] words[$];
   int errors = 0, total_checks = 0, cycles = 0;
   // Pin levels resolved from the controller's enables; the host model drives the rest
   assign config_clock = clk_pin_oe ? clk_pin_o : host_clk;
   assign data_pins = {pins[15:2], d1_pin_oe ? d1_pin_o : pins[1], d0_pin_oe ? d0_pin_o : pins[0]};
   always #25 clk_sys = ~clk_sys;
   config_clock_data_pin_control config_clock_data_pin_control_i (
      .clk_sys, .rst_n, .config_clock, .scheme_strap(strap), .ap_word_wide(wide),
      .dual_purpose_user_io(dual), .release_clock_pin(rel), .config_complete(done),
      .user_clk_o(usr[0]), .user_clk_oe(usr[1]), .user_d0_o(usr[2]), .user_d0_oe(usr[3]),
      .user_d1_o(usr[4]), .user_d1_oe(usr[5]), .data_pins, .clk_pin_o, .clk_pin_oe,
      .d0_pin_o, .d0_pin_oe, .d1_pin_o, .d1_pin_oe, .word_data, .word_valid, .word_ready,
      .user_mode, .overrun);
   cfg_host_model cfg_host_model_i (.active(strap[1]), .host_clk, .pins);
   // Record every word the core takes; cut a hang short
   always @(posedge clk_sys) begin
      if (rst_n && word_valid && word_ready)
         words.push_back(word_data);
      cycles++;
      if (cycles == 6000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic check_words(input logic [15:0] exp);
      check("word count", 16'h1, 16'(words.size() != 0));
      foreach (words[i]) check("word", exp, words[i]);
   endtask : check_words
   // Reset with the link clock ticking so the link side resets too
   task automatic restart(input logic [1:0] s, input logic w);
      strap = s;
      wide = w;
      {done, rel, dual, usr, word_ready} = 10'h001;
      rst_n = 1'b0;
      cfg_host_model_i.frame(12, 16'hffff);
      step(1);
      rst_n = 1'b1;
      words.delete();
      step(4);
   endtask : restart
   // Passive serial load, then user mode behaviour of the pins
   task automatic ps_case();
      int n;
      restart(2'h0, 1'b0);
      {dual, rel, usr} = 8'hcf;
      step(16);
      check("clk oe", 16'h0, 16'(clk_pin_oe));
      check("d1 oe", 16'h0, 16'(d1_pin_oe));
      // Six edges bring the link out of reset; then one byte a frame so each is acked
      cfg_host_model_i.frame(6, 16'hffff);
      repeat (3) begin
         cfg_host_model_i.frame(8, 16'hffff);
         step(10);
      end
      step(20);
      check_words(16'h00ff);
      check("overrun", 16'h0, 16'(overrun));
      done = 1'b1;
      step(5);
      check("mode", 16'h1, 16'(user_mode));
      check("clk oe", 16'h0, 16'(clk_pin_oe));
      check("d0", 16'h3, {14'h0, d0_pin_oe, d0_pin_o});
      n = words.size();
      cfg_host_model_i.frame(16, 16'h0000);
      step(20);
      check("late words", 16'(n), 16'(words.size()));
      check("mode", 16'h1, 16'(user_mode));
      $display("passive serial case done");
   endtask : ps_case
   // Fast passive parallel: a byte per edge; a second edge before the ack is dropped
   task automatic fpp_case();
      restart(2'h1, 1'b0);
      step(4);
      cfg_host_model_i.frame(6, 16'hffff);
      cfg_host_model_i.frame(2, 16'h015a);
      step(20);
      check_words(16'h005a);
      check("overrun", 16'h1, 16'(overrun));
      {done, dual, usr} = 8'hff;
      step(5);
      check("d1", 16'h3, {14'h0, d1_pin_oe, d1_pin_o});
      $display("fast passive parallel case done");
   endtask : fpp_case
   // Parallel flash load; the wide run fills the buffer with the core stalled
   task automatic ap_case(input logic w);
      logic held;
      restart(2'h3, w);
      word_ready = !w;
      usr = 6'h30;
      step(w ? 700 : 100);
      check("clk oe", 16'h1, 16'(clk_pin_oe));
      held = clk_pin_o;
      step(40);
      if (w) check("clk held", 16'(held), 16'(clk_pin_o));
      word_ready = 1'b1;
      step(50);
      if (w) check("fill", 16'h1, 16'(words.size() >= 32));
      check_words(w ? 16'hc3a5 : 16'h00a5);
      done = 1'b1;
      step(20);
      check("parked", 16'h2, {14'h0, clk_pin_oe, clk_pin_o});
      check("d1", 16'h3, {14'h0, d1_pin_oe, d1_pin_o});
      $display("active parallel case done");
   endtask : ap_case
   // Serial flash: read command out on data bit one, bits in on data bit zero
   task automatic as_case();
      logic [7:0] cmd;
      restart(2'h2, 1'b0);
      repeat (8) begin
         @(posedge clk_pin_o);
         cmd = {cmd[6:0], d1_pin_o};
      end
      check("command", 16'h0003, {8'h00, cmd});
      step(300);
      check_words(16'h00ff);
      usr = 6'h03;
      done = 1'b1;
      step(20);
      check("parked", 16'h2, {14'h0, clk_pin_oe, clk_pin_o});
      check("d0 oe", 16'h0, 16'(d0_pin_oe));
      check("d1 oe", 16'h1, 16'(d1_pin_oe));
      rel = 1'b1;
      step(5);
      check("released", 16'h3, {14'h0, clk_pin_oe, clk_pin_o});
      $display("active serial case done");
   endtask : as_case
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      ps_case();
      fpp_case();
      ap_case(1'b1);
      ap_case(1'b0);
      as_case();
      report_and_stop();
   end
endmodule : config_clock_data_pin_control_tb
`default_nettype wire
